// ===== amp_cfg_params.svh
// constants for the amplifier input, gain and mute configuration registers
`ifndef AMP_CFG_PARAMS_SVH
`define AMP_CFG_PARAMS_SVH

// ==========================================================
// register offsets
`define ADDR_INPUT_FORMAT_RATE_CLOCK 8'h10
`define ADDR_LEFT_GAIN_MUTE 8'h20
`define ADDR_RIGHT_GAIN_MUTE 8'h21

// ==========================================================
// input settings fields
`define FMT_LSB 0
`define FMT_MSB 2
`define RATE_LSB 3
`define RATE_MSB 4
`define MCLK_LSB 5
`define MCLK_MSB 6
`define FIXED_ZERO_BIT 7
`define INPUT_SETTINGS_RESET 8'h08

// ==========================================================
// gain register fields
`define GAIN_LSB 0
`define GAIN_MSB 5
`define UNMUTE_N_BIT 6
`define STOP_BIT 7
`define GAIN_REG_RESET 8'h00
`define GAIN_CODE_RESET 6'h00

// ==========================================================
// master clock ratios in fs for the 32 and 48 kHz groups
`define MCLK_FS_256 10'h100
`define MCLK_FS_384 10'h180
`define MCLK_FS_512 10'h200
`define MCLK_FS_768 10'h300

// ==========================================================
// gain ramp timing
`define CLOCK_PERIOD_NS 4
`define RAMP_STEP_NS 1000
`define RAMP_STEP_CYCLES (`RAMP_STEP_NS / `CLOCK_PERIOD_NS)
`define RAMP_CNT_W 8
`define RAMP_CNT_LAST 8'(`RAMP_STEP_CYCLES - 1)

`endif

// ===== amp_cfg_pkg.sv
// types for the amplifier input, gain and mute configuration registers
`default_nettype none
package amp_cfg_pkg;

   // ==========================================================
   // decoded serial input framing
   typedef enum logic [2:0] {
      fmt_i2s,
      fmt_left_msb,
      fmt_right_lsb,
      fmt_right_msb_24,
      fmt_right_msb_20,
      fmt_right_msb_18,
      fmt_right_msb_16,
      fmt_illegal
   } input_format_t;

   // ==========================================================
   // sample rate groups
   typedef enum logic [1:0] {
      rate_32k,
      rate_48k,
      rate_96k,
      rate_192k
   } rate_group_t;

endpackage : amp_cfg_pkg
`default_nettype wire

// ===== audio_input_gain_config_regs.sv
// register bank for input format, rate, clock ratio, gain and mute settings
`timescale 1ns/1ps
`default_nettype none
`include "amp_cfg_params.svh"

// Contract
// - 3-bit format code at 0x10 bits 2:0
// - register format only when combined, straps low
// - decode format codes 000 to 110
// - clock ratio 6:5, rate 4:3, bit7 zero
// - register ratio only when combined, strap low
// - register rate only when combined, strap low
// - decode rate group codes 00 to 11
// - master clock ratio table per rate group
// - mismatched settings may switch outputs off
// - 6-bit gains at 0x20 and 0x21
// - code 111111 is +12 dB, 1.5 dB steps
// - register gains only when combined, straps low
// - bit6 channel unmute, bit7 channel output stop
// - input settings reset to 0x08
// - mute and stop bits reset to zero
module audio_input_gain_config_regs (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // register port from the serial bus slave
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // mode and strap pins
   input wire logic combined_mode_i,
   input wire logic [2:0] format_strap_i,
   input wire logic mclk_ratio_strap_i,
   input wire logic rate_group_strap_i,
   input wire logic [5:0] gain_strap_i,
   // pin-selected settings
   input wire logic [2:0] pin_format_i,
   input wire logic [1:0] pin_rate_group_i,
   input wire logic [1:0] pin_mclk_ratio_i,
   input wire logic [5:0] pin_gain_i,
   // effective settings
   output amp_cfg_pkg::input_format_t format_o,
   output amp_cfg_pkg::rate_group_t rate_group_o,
   output logic [1:0] mclk_ratio_o,
   output logic [9:0] mclk_per_fs_o,
   output logic config_illegal_o,
   // per-channel gain and output control
   output logic [5:0] left_gain_code_o,
   output logic [5:0] right_gain_code_o,
   output logic left_unmute_n_o,
   output logic right_unmute_n_o,
   output logic left_output_stop_o,
   output logic right_output_stop_o
);
   import amp_cfg_pkg::*;

   // ==========================================================
   // registers
   logic [7:0] input_settings_ff;
   logic [7:0] left_gain_mute_ff;
   logic [7:0] right_gain_mute_ff;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         input_settings_ff <= `INPUT_SETTINGS_RESET;
      end else if (reg_wr_i && reg_addr_i == `ADDR_INPUT_FORMAT_RATE_CLOCK) begin
         input_settings_ff <= {1'b0, reg_wdata_i[`MCLK_MSB:`FMT_LSB]};
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         left_gain_mute_ff <= `GAIN_REG_RESET;
         right_gain_mute_ff <= `GAIN_REG_RESET;
      end else if (reg_wr_i) begin
         if (reg_addr_i == `ADDR_LEFT_GAIN_MUTE) begin
            left_gain_mute_ff <= reg_wdata_i;
         end
         if (reg_addr_i == `ADDR_RIGHT_GAIN_MUTE) begin
            right_gain_mute_ff <= reg_wdata_i;
         end
      end
   end

   // ==========================================================
   // read back
   logic [7:0] nxt_rdata;

   always_comb begin
      unique case (reg_addr_i)
         `ADDR_INPUT_FORMAT_RATE_CLOCK: nxt_rdata = input_settings_ff;
         `ADDR_LEFT_GAIN_MUTE: nxt_rdata = left_gain_mute_ff;
         `ADDR_RIGHT_GAIN_MUTE: nxt_rdata = right_gain_mute_ff;
         default: nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else begin
         reg_rdata_o <= nxt_rdata;
      end
   end

   // ==========================================================
   // register or pin source selection
   logic use_reg_format;
   logic use_reg_rate;
   logic use_reg_mclk;
   logic use_reg_gain;
   logic [2:0] sel_format;
   logic [1:0] sel_rate;
   logic [1:0] sel_mclk;
   logic [5:0] sel_left_gain;
   logic [5:0] sel_right_gain;

   assign use_reg_format = combined_mode_i && (format_strap_i == 3'h0);
   assign use_reg_rate = combined_mode_i && !rate_group_strap_i;
   assign use_reg_mclk = combined_mode_i && !mclk_ratio_strap_i;
   assign use_reg_gain = combined_mode_i && (gain_strap_i == 6'h00);
   assign sel_format = use_reg_format ? input_settings_ff[`FMT_MSB:`FMT_LSB] : pin_format_i;
   assign sel_rate = use_reg_rate ? input_settings_ff[`RATE_MSB:`RATE_LSB] : pin_rate_group_i;
   assign sel_mclk = use_reg_mclk ? input_settings_ff[`MCLK_MSB:`MCLK_LSB] : pin_mclk_ratio_i;
   assign sel_left_gain = use_reg_gain ? left_gain_mute_ff[`GAIN_MSB:`GAIN_LSB] : pin_gain_i;
   assign sel_right_gain = use_reg_gain ? right_gain_mute_ff[`GAIN_MSB:`GAIN_LSB] : pin_gain_i;

   // ==========================================================
   // decode of format, rate and master clock ratio
   input_format_t nxt_format;
   logic [9:0] base_ratio;
   logic [9:0] nxt_mclk_per_fs;

   always_comb begin
      unique case (sel_format)
         3'h0: nxt_format = fmt_i2s;
         3'h1: nxt_format = fmt_left_msb;
         3'h2: nxt_format = fmt_right_lsb;
         3'h3: nxt_format = fmt_right_msb_24;
         3'h4: nxt_format = fmt_right_msb_20;
         3'h5: nxt_format = fmt_right_msb_18;
         3'h6: nxt_format = fmt_right_msb_16;
         default: nxt_format = fmt_illegal;
      endcase
   end

   always_comb begin
      unique case (sel_mclk)
         2'h0: base_ratio = `MCLK_FS_256;
         2'h1: base_ratio = `MCLK_FS_384;
         2'h2: base_ratio = `MCLK_FS_512;
         default: base_ratio = `MCLK_FS_768;
      endcase
      unique case (rate_group_t'(sel_rate))
         rate_96k: nxt_mclk_per_fs = base_ratio >> 1;
         rate_192k: nxt_mclk_per_fs = base_ratio >> 2;
         default: nxt_mclk_per_fs = base_ratio;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         format_o <= fmt_i2s;
         rate_group_o <= rate_48k;
         mclk_ratio_o <= 2'h0;
         mclk_per_fs_o <= `MCLK_FS_256;
         config_illegal_o <= 1'b0;
      end else begin
         format_o <= nxt_format;
         rate_group_o <= rate_group_t'(sel_rate);
         mclk_ratio_o <= sel_mclk;
         mclk_per_fs_o <= nxt_mclk_per_fs;
         config_illegal_o <= (nxt_format == fmt_illegal);
      end
   end

   // ==========================================================
   // mute and output stop; illegal format forces outputs off
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         left_unmute_n_o <= 1'b0;
         right_unmute_n_o <= 1'b0;
         left_output_stop_o <= 1'b0;
         right_output_stop_o <= 1'b0;
      end else begin
         left_unmute_n_o <= left_gain_mute_ff[`UNMUTE_N_BIT];
         right_unmute_n_o <= right_gain_mute_ff[`UNMUTE_N_BIT];
         left_output_stop_o <= left_gain_mute_ff[`STOP_BIT] || (nxt_format == fmt_illegal);
         right_output_stop_o <= right_gain_mute_ff[`STOP_BIT] || (nxt_format == fmt_illegal);
      end
   end

   // ==========================================================
   // gain ramp step enable
   logic [`RAMP_CNT_W-1:0] ramp_cnt_ff;
   logic ramp_tick;

   assign ramp_tick = (ramp_cnt_ff == `RAMP_CNT_LAST);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ramp_cnt_ff <= '0;
      end else if (ramp_tick) begin
         ramp_cnt_ff <= '0;
      end else begin
         ramp_cnt_ff <= ramp_cnt_ff + 1'b1;
      end
   end

   // ==========================================================
   // per-channel gain ramp, one code (1.5 dB) per step
   logic [5:0] target_gain [2];
   logic [5:0] gain_ff [2];

   assign target_gain[0] = sel_left_gain;
   assign target_gain[1] = sel_right_gain;

   generate
      for (genvar ch = 0; ch < 2; ch++) begin : g_ramp
         always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               gain_ff[ch] <= `GAIN_CODE_RESET;
            end else if (ramp_tick && gain_ff[ch] < target_gain[ch]) begin
               gain_ff[ch] <= gain_ff[ch] + 6'h01;
            end else if (ramp_tick && gain_ff[ch] > target_gain[ch]) begin
               gain_ff[ch] <= gain_ff[ch] - 6'h01;
            end
         end
      end
   endgenerate

   assign left_gain_code_o = gain_ff[0];
   assign right_gain_code_o = gain_ff[1];

endmodule : audio_input_gain_config_regs
`default_nettype wire

// ===== audio_cfg_checker.sv
// concurrent checks on the configuration register ports
`timescale 1ns/1ps
`default_nettype none
module audio_cfg_checker (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // register port
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   // mode and pins
   input wire logic combined_mode_i,
   input wire logic [2:0] pin_format_i,
   // effective settings
   input wire amp_cfg_pkg::input_format_t format_o,
   input wire amp_cfg_pkg::rate_group_t rate_group_o,
   input wire logic [1:0] mclk_ratio_o,
   input wire logic [9:0] mclk_per_fs_o,
   input wire logic config_illegal_o,
   input wire logic [5:0] left_gain_code_o,
   input wire logic left_output_stop_o,
   input wire logic right_output_stop_o
);
   import amp_cfg_pkg::*;
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   // ==========================================================
   // assertions
   chk_illegal_flag: assert property (
      !combined_mode_i |=> config_illegal_o == (&$past(pin_format_i)))
      else $error("illegal flag wrong");
   chk_stop_forced: assert property (config_illegal_o |-> left_output_stop_o && right_output_stop_o)
      else $error("stop not forced");
   chk_format_pin: assert property (!combined_mode_i |=> format_o == $past(pin_format_i))
      else $error("pin format not used");
   chk_mclk_table: assert property (
      mclk_per_fs_o == (((mclk_ratio_o[0] ? 10'h180 : 10'h100) << mclk_ratio_o[1])
      >> (rate_group_o[1] ? rate_group_o[0] + 2'h1 : 2'h0)))
      else $error("clock ratio wrong");
   chk_unmapped_zero: assert property (
      !(reg_addr_i inside {8'h10, 8'h20, 8'h21}) |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   chk_gain_readback: assert property (
      reg_wr_i && reg_addr_i == 8'h20 ##1 reg_addr_i == 8'h20 |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("gain readback wrong");
   chk_fixed_zero: assert property (
      reg_wr_i && reg_addr_i == 8'h10 ##1 reg_addr_i == 8'h10
      |=> reg_rdata_o == {1'b0, $past(reg_wdata_i[6:0], 2)})
      else $error("settings readback wrong");
   chk_gain_step: assert property (
      left_gain_code_o == $past(left_gain_code_o) || left_gain_code_o == $past(left_gain_code_o)
      + 6'h01 || left_gain_code_o == $past(left_gain_code_o) - 6'h01)
      else $error("gain jumped");
endmodule : audio_cfg_checker
bind audio_input_gain_config_regs audio_cfg_checker chk_u (
   .clock_i, .rst_n_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .combined_mode_i,
   .pin_format_i, .format_o, .rate_group_o, .mclk_ratio_o, .mclk_per_fs_o, .config_illegal_o,
   .left_gain_code_o, .left_output_stop_o, .right_output_stop_o
);
`default_nettype wire

// ===== bus_host_model.sv
// bus host stand-in driving the byte register port
`timescale 1ns/1ps
`default_nettype none
module bus_host_model (
   // clock
   input wire logic clock_i,
   // register port
   input wire logic [7:0] reg_rdata_i,
   output logic reg_wr_o = 1'b0,
   output logic [7:0] reg_addr_o = 8'h00,
   output logic [7:0] reg_wdata_o = 8'h00
);
   // ==========================================================
   // transfers
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clock_i);
      reg_wr_o <= 1'b1;
      reg_addr_o <= addr;
      reg_wdata_o <= data;
      @(posedge clock_i);
      reg_wr_o <= 1'b0;
      reg_wdata_o <= ~data;
   endtask : write_reg
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clock_i);
      reg_addr_o <= addr;
      @(posedge clock_i);
      #1 data = reg_rdata_i;
   endtask : read_reg
endmodule : bus_host_model
`default_nettype wire

// ===== audio_input_gain_config_regs_test.sv
// self-checking bench for the configuration registers
`timescale 1ns/1ps
`default_nettype none
module audio_input_gain_config_regs_test;
   import amp_cfg_pkg::*;
   // ==========================================================
   // signals
   typedef struct packed {
      logic c;
      logic [2:0] fs;
      logic rs;
      logic ms;
      logic [2:0] pf;
      logic [1:0] pr;
      logic [1:0] pm;
      logic [7:0] rv;
      logic [2:0] ef;
      logic [1:0] er;
      logic [1:0] em;
      logic [9:0] mf;
   } row_t;
   row_t rows [12] = '{'{1,0,0,0,0,0,0,8'h80,0,0,0,10'h100}, '{1,0,0,0,0,0,0,8'h79,1,3,3,10'h0C0},
      '{1,0,0,0,0,0,0,8'h52,2,2,2,10'h100}, '{1,0,0,0,0,0,0,8'h2B,3,1,1,10'h180},
      '{1,0,0,0,0,0,0,8'h64,4,0,3,10'h300}, '{1,0,0,0,0,0,0,8'h35,5,2,1,10'h0C0},
      '{1,0,0,0,0,0,0,8'h4E,6,1,2,10'h200}, '{1,0,0,0,0,0,0,8'h1F,7,3,0,10'h040},
      '{0,0,0,0,3,2,3,8'h1F,3,2,3,10'h180}, '{1,4,1,0,2,0,1,8'h79,2,0,3,10'h300},
      '{0,0,0,0,7,1,2,8'h1F,7,1,2,10'h200}, '{1,0,0,1,0,0,0,8'h52,2,2,0,10'h080}};
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic reg_wr_i, combined_mode_i = 1'b1, mclk_ratio_strap_i = 1'b0, rate_group_strap_i = 1'b0;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd;
   logic [2:0] format_strap_i = 3'h0, pin_format_i = 3'h0;
   logic [1:0] pin_rate_group_i = 2'h0, pin_mclk_ratio_i = 2'h0, mclk_ratio_o;
   logic [5:0] gain_strap_i = 6'h00, pin_gain_i = 6'h00, left_gain_code_o, right_gain_code_o;
   input_format_t format_o;
   rate_group_t rate_group_o;
   logic [9:0] mclk_per_fs_o;
   logic config_illegal_o, left_unmute_n_o, right_unmute_n_o;
   logic left_output_stop_o, right_output_stop_o;
   int mismatches = 0;
   int n_checks = 0;
   // ==========================================================
   // instances
   audio_input_gain_config_regs dut_u (.clock_i, .rst_n_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
      .reg_rdata_o, .combined_mode_i, .format_strap_i, .mclk_ratio_strap_i, .rate_group_strap_i,
      .gain_strap_i, .pin_format_i, .pin_rate_group_i, .pin_mclk_ratio_i, .pin_gain_i, .format_o,
      .rate_group_o, .mclk_ratio_o, .mclk_per_fs_o, .config_illegal_o, .left_gain_code_o,
      .right_gain_code_o, .left_unmute_n_o, .right_unmute_n_o, .left_output_stop_o,
      .right_output_stop_o);
   bus_host_model host_u (.clock_i, .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
      .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
   always #2 clock_i = ~clock_i;
   // ==========================================================
   // checking and verdict
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   initial begin
      #60000;
      mismatches++;
      give_verdict();
   end
   // ==========================================================
   // scenarios
   initial begin
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      // settings change while both channels are still unmuted from reset, clock ratios from 64 to 768 fs
      foreach (rows[i]) begin
         @(posedge clock_i);
         {combined_mode_i, format_strap_i, rate_group_strap_i} <= {rows[i].c, rows[i].fs, rows[i].rs};
         {mclk_ratio_strap_i, pin_format_i} <= {rows[i].ms, rows[i].pf};
         {pin_rate_group_i, pin_mclk_ratio_i} <= {rows[i].pr, rows[i].pm};
         host_u.write_reg(8'h10, rows[i].rv);
         host_u.read_reg(8'h10, rd);
         check(rd, {1'b0, rows[i].rv[6:0]});
         check(format_o, rows[i].ef);
         check(rate_group_o, rows[i].er);
         check(mclk_ratio_o, rows[i].em);
         check(mclk_per_fs_o, rows[i].mf);
         check({config_illegal_o, left_output_stop_o}, {2{rows[i].ef == 3'h7}});
      end
      host_u.write_reg(8'h20, 8'h43);
      host_u.write_reg(8'h21, 8'h82);
      host_u.read_reg(8'h21, rd);
      check(rd, 16'h0082);
      check({left_unmute_n_o, right_unmute_n_o, left_output_stop_o, right_output_stop_o}, 4'h9);
      repeat (1100) @(posedge clock_i);
      #1 check({left_gain_code_o, right_gain_code_o}, {6'h03, 6'h02});
      @(posedge clock_i);
      gain_strap_i <= 6'h01;
      pin_gain_i <= 6'h05;
      repeat (1100) @(posedge clock_i);
      #1 check({left_gain_code_o, right_gain_code_o}, {6'h05, 6'h05});
      host_u.write_reg(8'h30, 8'hFF);
      host_u.read_reg(8'h30, rd);
      check(rd, 16'h0000);
      host_u.read_reg(8'h10, rd);
      check(rd, 16'h0052);
      @(posedge clock_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      foreach (rows[i]) if (i < 3) begin
         host_u.read_reg(i == 0 ? 8'h10 : 8'h1F + 8'(i), rd);
         check(rd, i == 0 ? 16'h0008 : 16'h0000);
      end
      check({left_unmute_n_o, right_unmute_n_o, left_output_stop_o, right_output_stop_o}, 4'h0);
      check({format_o, rate_group_o}, 5'h01);
      give_verdict();
   end
endmodule : audio_input_gain_config_regs_test
`default_nettype wire
